// [hw/rcc_pkg.sv]
// Purpose: shared constants and types of the channel 2 config register bank
// Assumes: 32-bit AXI4-Lite, one aligned word per register
// Notes: printed offsets are word indices; byte address is four times index
package rcc_pkg;
  localparam int RCC_DATA_W = 32;
  localparam int RCC_ADDR_W = 12;

  // word indices
  localparam logic [7:0] RCC_IDX_VOLTAGE = 8'h2d;
  localparam logic [7:0] RCC_IDX_MODE = 8'h2e;
  localparam logic [7:0] RCC_IDX_BIAS = 8'h40;
  localparam logic [7:0] RCC_IDX_STATUS = 8'h41;

  // field positions in the mode/limit/enable register
  localparam int RCC_MODE_LSB = 6;
  localparam int RCC_ILIM_LSB = 4;
  localparam int RCC_ADE_BIT = 3;
  localparam int RCC_EN_LSB = 0;
  localparam int RCC_EN_FORCE_BIT = 2;
  localparam int RCC_EN_ON_BIT = 1;

  // bias and status bit positions
  localparam int RCC_BIAS_LPM_BIT = 0;
  localparam int RCC_STAT_ENABLED_BIT = 0;
  localparam int RCC_STAT_DISCHARGE_BIT = 1;

  // reset values (voltage and mode defaults stand in as top parameters)
  localparam logic [7:0] RCC_VOLTAGE_RESET = 8'h00;
  localparam logic [7:0] RCC_MODE_RESET = 8'h00;
  localparam logic RCC_BIAS_RESET = 1'b0;

  // voltage transfer in millivolts: 500 base, 25 step
  localparam logic [12:0] RCC_VOUT_BASE_MV = 13'h01f4;
  localparam logic [12:0] RCC_VOUT_STEP_MV = 13'h0019;

  // peak current limits in milliamps: 1000, 750, 500, 333
  localparam logic [9:0] RCC_ILIM0_MA = 10'h3e8;
  localparam logic [9:0] RCC_ILIM1_MA = 10'h2ee;
  localparam logic [9:0] RCC_ILIM2_MA = 10'h1f4;
  localparam logic [9:0] RCC_ILIM3_MA = 10'h14d;

  localparam logic [1:0] RCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RCC_MODE_AUTO,
    RCC_MODE_BUCK,
    RCC_MODE_BOOST,
    RCC_MODE_BUCK_BOOST
  } rcc_mode_t;
endpackage

// [hw/rcc_decode.sv]
// Purpose: turns the stored fields into converter settings
// Assumes: fields come straight from the register flops
// Notes: outputs are registered, one cycle behind the register
`timescale 1ns/1ps
module rcc_decode (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] voltage_code,
  input wire logic [1:0] mode_field,
  input wire logic [1:0] ilim_field,
  output rcc_pkg::rcc_mode_t converter_operating_mode,
  output logic [12:0] channel2_target_voltage_mv,
  output logic [9:0] channel2_peak_current_limit_ma
);
  import rcc_pkg::*;

  rcc_mode_t next_mode;
  logic [12:0] next_vout;
  logic [9:0] next_ilim;

  always_comb begin
    // mode codes map onto the enum order
    next_mode = rcc_mode_t'(mode_field);
    // 255 * 25 + 500 stays below 8192
    next_vout = RCC_VOUT_BASE_MV
      + 13'(13'(voltage_code) * RCC_VOUT_STEP_MV);
    unique case (ilim_field)
      2'h0: next_ilim = RCC_ILIM0_MA;
      2'h1: next_ilim = RCC_ILIM1_MA;
      2'h2: next_ilim = RCC_ILIM2_MA;
      2'h3: next_ilim = RCC_ILIM3_MA;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_operating_mode <= RCC_MODE_AUTO;
      channel2_target_voltage_mv <= RCC_VOUT_BASE_MV;
      channel2_peak_current_limit_ma <= RCC_ILIM0_MA;
    end else begin
      converter_operating_mode <= next_mode;
      channel2_target_voltage_mv <= next_vout;
      channel2_peak_current_limit_ma <= next_ilim;
    end
  end
endmodule

// [hw/rcc_enable.sv]
// Purpose: resolves channel on/off and the active discharge switch
// Assumes: sequencer gives one level per slot, high while slot is up
// Notes: discharge only ever engages while the channel is off
`timescale 1ns/1ps
module rcc_enable #(
  parameter int SLOTS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] enable_control,
  input wire logic discharge_enable,
  input wire logic [SLOTS-1:0] power_sequencer_slot_on,
  output logic channel2_on,
  output logic channel2_discharge_on
);
  import rcc_pkg::*;

  logic next_on;
  logic next_discharge;

  always_comb begin
    if (enable_control[RCC_EN_FORCE_BIT]) begin
      // forced codes ignore the sequencer entirely
      next_on = enable_control[RCC_EN_ON_BIT];
    end else begin
      next_on = power_sequencer_slot_on[enable_control[1:0]];
    end
    // clear bit leaves the output to decay through the load
    next_discharge = discharge_enable && !next_on;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel2_on <= 1'b0;
      channel2_discharge_on <= 1'b0;
    end else begin
      channel2_on <= next_on;
      channel2_discharge_on <= next_discharge;
    end
  end
endmodule

// [hw/rcc_regs.sv]
// Purpose: AXI4-Lite register bank for converter channel 2 configuration
// Assumes: one write and one read under way at most
// Notes: reset values of the two config words are top parameters
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module rcc_regs #(
  parameter int ADDR_W = rcc_pkg::RCC_ADDR_W,
  parameter int SLOTS = 4,
  parameter logic [7:0] VOLTAGE_RESET = rcc_pkg::RCC_VOLTAGE_RESET,
  parameter logic [7:0] MODE_RESET = rcc_pkg::RCC_MODE_RESET
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rcc_pkg::RCC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rcc_pkg::RCC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [SLOTS-1:0] power_sequencer_slot_on,
  output rcc_pkg::rcc_mode_t converter_operating_mode,
  output logic [12:0] channel2_target_voltage_mv,
  output logic [9:0] channel2_peak_current_limit_ma,
  output logic channel2_on,
  output logic channel2_discharge_on,
  output logic bias_low_power_select
);
  import rcc_pkg::*;

  // register state
  logic [7:0] channel2_output_voltage_code;
  logic [7:0] channel2_mode_limit_enable;
  logic bias_lpm;
  logic [7:0] next_voltage_code;
  logic [7:0] next_mode_limit_enable;
  logic next_bias_lpm;

  // write channel state
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;
  logic bvalid;
  logic [1:0] bresp;
  logic next_aw_held;
  logic next_w_held;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [7:0] next_wr_byte;
  logic next_wr_lane0;
  logic next_bvalid;
  logic [1:0] next_bresp;

  // read channel state
  logic rvalid;
  logic [RCC_DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic next_rvalid;
  logic [RCC_DATA_W-1:0] next_rdata;
  logic [1:0] next_rresp;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [7:0] status_byte;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [7:0] idx);
    addr_hit = addr[ADDR_W-1:2] == (ADDR_W-2)'(idx);
  endfunction

  // a new write is held off until the previous response is taken
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign bias_low_power_select = bias_lpm;

  always_comb begin
    status_byte = 8'h00;
    status_byte[RCC_STAT_ENABLED_BIT] = channel2_on;
    status_byte[RCC_STAT_DISCHARGE_BIT] = channel2_discharge_on;
  end

  // write path: address and data taken in either order
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_wr_addr = wr_addr;
    next_wr_byte = wr_byte;
    next_wr_lane0 = wr_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_voltage_code = channel2_output_voltage_code;
    next_mode_limit_enable = channel2_mode_limit_enable;
    next_bias_lpm = bias_lpm;
    if (aw_take) begin
      next_aw_held = 1'b1;
      next_wr_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_w_held = 1'b1;
      next_wr_byte = s_axi_wdata[7:0];
      next_wr_lane0 = s_axi_wstrb[0];
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RCC_RESP_OKAY;
      if (addr_hit(wr_addr, RCC_IDX_VOLTAGE)) begin
        if (wr_lane0) begin
          next_voltage_code = wr_byte;
        end
      end else if (addr_hit(wr_addr, RCC_IDX_MODE)) begin
        if (wr_lane0) begin
          next_mode_limit_enable = wr_byte;
        end
      end else if (addr_hit(wr_addr, RCC_IDX_BIAS)) begin
        // sequencing of this bit around enable is left to software
        if (wr_lane0) begin
          next_bias_lpm = wr_byte[RCC_BIAS_LPM_BIT];
        end
      end else if (!addr_hit(wr_addr, RCC_IDX_STATUS)) begin
        next_bresp = RCC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_byte <= 8'h00;
      wr_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RCC_RESP_OKAY;
      channel2_output_voltage_code <= VOLTAGE_RESET;
      channel2_mode_limit_enable <= MODE_RESET;
      bias_lpm <= RCC_BIAS_RESET;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_byte <= next_wr_byte;
      wr_lane0 <= next_wr_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      channel2_output_voltage_code <= next_voltage_code;
      channel2_mode_limit_enable <= next_mode_limit_enable;
      bias_lpm <= next_bias_lpm;
    end
  end

  // read path: answer one cycle after the address is taken
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rresp = RCC_RESP_OKAY;
      next_rdata = '0;
      if (addr_hit(s_axi_araddr, RCC_IDX_VOLTAGE)) begin
        next_rdata[7:0] = channel2_output_voltage_code;
      end else if (addr_hit(s_axi_araddr, RCC_IDX_MODE)) begin
        next_rdata[7:0] = channel2_mode_limit_enable;
      end else if (addr_hit(s_axi_araddr, RCC_IDX_BIAS)) begin
        next_rdata[RCC_BIAS_LPM_BIT] = bias_lpm;
      end else if (addr_hit(s_axi_araddr, RCC_IDX_STATUS)) begin
        next_rdata[7:0] = status_byte;
      end else begin
        next_rresp = RCC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RCC_RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  rcc_decode u_decode (
    .aclk(aclk),
    .aresetn(aresetn),
    .voltage_code(channel2_output_voltage_code),
    .mode_field(channel2_mode_limit_enable[RCC_MODE_LSB+:2]),
    .ilim_field(channel2_mode_limit_enable[RCC_ILIM_LSB+:2]),
    .converter_operating_mode(converter_operating_mode),
    .channel2_target_voltage_mv(channel2_target_voltage_mv),
    .channel2_peak_current_limit_ma(channel2_peak_current_limit_ma)
  );

  rcc_enable #(
    .SLOTS(SLOTS)
  ) u_enable (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable_control(channel2_mode_limit_enable[RCC_EN_LSB+:3]),
    .discharge_enable(channel2_mode_limit_enable[RCC_ADE_BIT]),
    .power_sequencer_slot_on(power_sequencer_slot_on),
    .channel2_on(channel2_on),
    .channel2_discharge_on(channel2_discharge_on)
  );
endmodule

// [testbench/rcc_regs_props.sv]
// Purpose: port checks for the channel 2 config register bank
// Assumes: one clock, synchronous active-low reset
// Notes: stored register values are judged by the bench
`timescale 1ns/1ps
module rcc_regs_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [12:0] channel2_target_voltage_mv,
  input wire logic [9:0] channel2_peak_current_limit_ma,
  input wire logic channel2_on,
  input wire logic channel2_discharge_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_discharge_when_off: assert property (
    channel2_discharge_on |-> !channel2_on)
    else $error("discharge resistor on while channel on");
  a_voltage_linear_step: assert property (
    channel2_target_voltage_mv >= 13'h01f4 &&
    (channel2_target_voltage_mv - 13'h01f4) % 25 == 0 &&
    channel2_target_voltage_mv <= 13'h1adb)
    else $error("target voltage off the 25 mV grid");
  a_ilim_legal_set: assert property (
    channel2_peak_current_limit_ma inside {10'h3e8, 10'h2ee, 10'h1f4, 10'h14d})
    else $error("peak current limit not a legal value");
  a_b_blocks_aw: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write readies high during response");
  a_b_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not cleared");
  a_r_blocks_ar: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready high during response");
  a_ar_next_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not cleared");
  a_rdata_zero_ext: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
endmodule
bind rcc_regs rcc_regs_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .channel2_target_voltage_mv(channel2_target_voltage_mv),
  .channel2_peak_current_limit_ma(channel2_peak_current_limit_ma),
  .channel2_on(channel2_on), .channel2_discharge_on(channel2_discharge_on));

// [testbench/rcc_regs_tb_top.sv]
// Purpose: self-checking bench for the channel 2 config register bank
// Assumes: bready and rready held high, so responses never stall
// Notes: bus answers checked from queues by a separate monitor
`timescale 1ns/1ps
module rcc_regs_tb_top;
  import rcc_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0, slot_on = 0;
  logic awvalid = 0, wvalid = 0, arvalid = 0, awready, wready, arready;
  logic bvalid, rvalid, on, dis, bias;
  logic [1:0] bresp, rresp;
  rcc_mode_t mode;
  logic [12:0] mv;
  logic [9:0] ilim;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [9:0] ilim_tab [4] = '{10'h3e8, 10'h2ee, 10'h1f4, 10'h14d};
  int fail_count = 0, comparisons = 0, cyc = 0, seed = 51;
  logic [3:0] sl;
  logic [7:0] code;
  logic exp_on;
  rcc_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .power_sequencer_slot_on(slot_on), .converter_operating_mode(mode),
    .channel2_target_voltage_mv(mv), .channel2_peak_current_limit_ma(ilim),
    .channel2_on(on), .channel2_discharge_on(dis),
    .bias_low_power_select(bias));
  initial forever #2 aclk = ~aclk;
  // wide enough that the response code rides along with read data
  task chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
          input logic [1:0] r);
    logic ad, wd;
    ad = 0;
    wd = 0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= {$random(seed)} << 8 | d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    @(posedge aclk);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    rq.push_back({r, 24'h00_0000, d});
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      end_sim();
    end
    if (bvalid) chk("bresp", bresp, bq.pop_front());
    if (rvalid) chk("rdata", {rresp, rdata}, rq.pop_front());
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk("mode rst", mode, 0);
    chk("mv rst", mv, 500);
    chk("ilim rst", ilim, 1000);
    rd(12'h0b4, 8'h00, RCC_RESP_OKAY);
    rd(12'h0b8, 8'h00, RCC_RESP_OKAY);
    rd(12'h100, 8'h00, RCC_RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 4; i++) begin
        wr(12'h0b8, {m[1:0], i[1:0], 4'h6}, 4'h1, RCC_RESP_OKAY);
        chk("mode", mode, m);
        chk("ilim", ilim, ilim_tab[i]);
        rd(12'h0b8, {m[1:0], i[1:0], 4'h6}, RCC_RESP_OKAY);
      end
    end
    for (int k = 0; k < 10; k++) begin
      code = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : $random(seed);
      wr(12'h0b4, code, 4'h1, RCC_RESP_OKAY);
      chk("mv", mv, 13'(500 + 25 * code));
      rd(12'h0b4, code, RCC_RESP_OKAY);
    end
    wr(12'h100, 8'h00, 4'h1, RCC_RESP_OKAY);
    for (int a = 0; a < 2; a++) begin
      for (int c = 0; c < 8; c++) begin
        sl = $random(seed);
        slot_on <= sl;
        wr(12'h0b8, {4'h0, a[0], c[2:0]}, 4'h1, RCC_RESP_OKAY);
        exp_on = c[2] ? c[1] : sl[c[1:0]];
        chk("on", on, exp_on);
        chk("discharge", dis, a[0] && !exp_on);
        rd(12'h104, {6'h00, a[0] && !exp_on, exp_on}, RCC_RESP_OKAY);
      end
    end
    wr(12'h100, 8'h01, 4'h1, RCC_RESP_OKAY);
    chk("bias", bias, 1);
    rd(12'h100, 8'h01, RCC_RESP_OKAY);
    wr(12'h0b4, 8'h55, 4'h0, RCC_RESP_OKAY);
    wr(12'h200, 8'h77, 4'h1, RCC_RESP_SLVERR);
    wr(12'h104, 8'hff, 4'h1, RCC_RESP_OKAY);
    // status stays read-only: last loop pass left the channel forced on
    rd(12'h104, 8'h01, RCC_RESP_OKAY);
    rd(12'h0b4, code, RCC_RESP_OKAY);
    rd(12'h200, 8'h00, RCC_RESP_SLVERR);
    repeat (3) @(posedge aclk);
    chk("queues", bq.size() + rq.size(), 0);
    end_sim();
  end
endmodule
